// [dv/gosm_output_mux_tb.sv]
// Self-checking bench for the output multiplexer of local pins 0 and 1.
// Assumes the design package is compiled first; one clock, no other bus.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end

module gosm_output_mux_tb;
    typedef struct packed {
        logic [2:0] sel;
        logic [1:0] en;
        logic [1:0] lk;
        logic [1:0] ps;
        logic exp;
    } gosm_case_t;
    // ----------------------------------------------------------------
    // Device status cases: pass and lock differ in every lock and pass select case with a port enabled
    // ----------------------------------------------------------------
    localparam gosm_case_t DEV_CASES[14] = '{
        '{3'h0, 2'h0, 2'h0, 2'h0, 1'b1}, '{3'h0, 2'h3, 2'h3, 2'h3, 1'b0},
        '{3'h1, 2'h1, 2'h2, 2'h3, 1'b0}, '{3'h1, 2'h3, 2'h2, 2'h0, 1'b1},
        '{3'h1, 2'h0, 2'h3, 2'h3, 1'b0}, '{3'h2, 2'h1, 2'h1, 2'h0, 1'b1},
        '{3'h2, 2'h3, 2'h1, 2'h3, 1'b0}, '{3'h2, 2'h0, 2'h3, 2'h3, 1'b0},
        '{3'h2, 2'h2, 2'h2, 2'h1, 1'b1}, '{3'h3, 2'h1, 2'h0, 2'h1, 1'b1},
        '{3'h3, 2'h3, 2'h3, 2'h1, 1'b0}, '{3'h3, 2'h2, 2'h3, 2'h2, 1'b1},
        '{3'h4, 2'h3, 2'h3, 2'h3, 1'b1}, '{3'h4, 2'h0, 2'h0, 2'h0, 1'b0}};

    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic reg_rd_valid;
    logic [1:0][3:0] rx_remote_gpio = '0;
    logic [1:0] rx_lock = 2'h0;
    logic [1:0] rx_pass = 2'h0;
    logic [1:0] rx_port_enable = 2'h0;
    logic frame_sync_signal = 1'b0;
    logic [1:0] pin_out;
    logic [1:0] pin_oe;
    logic [1:0] pin_level;
    logic [7:0] rd;
    int error_cnt = 0;
    int checks = 0;
    int cycles = 0;

    always #12.5 clk_sys = ~clk_sys;

    gosm_output_mux #(.NUM_PINS(2)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
        .rx_remote_gpio(rx_remote_gpio), .rx_lock(rx_lock), .rx_pass(rx_pass),
        .rx_port_enable(rx_port_enable), .frame_sync_signal(frame_sync_signal),
        .pin_out(pin_out), .pin_oe(pin_oe));
    gosm_pin_load u_load0 (.clk_sys(clk_sys), .rst_n(rst_n), .pin_out(pin_out[0]),
        .pin_oe(pin_oe[0]), .pin_level(pin_level[0]));
    gosm_pin_load u_load1 (.clk_sys(clk_sys), .rst_n(rst_n), .pin_out(pin_out[1]),
        .pin_oe(pin_oe[1]), .pin_level(pin_level[1]));

    // ----------------------------------------------------------------
    // Bus and stimulus helpers
    // ----------------------------------------------------------------
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr_en <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd_en <= 1'b0;
        #1;
        `CHK(reg_rd_valid, 1'b1)
        d = reg_rdata;
    endtask

    // Write, then three edges for the control and output registers
    task automatic set_pin(input int p, input logic [7:0] c);
        reg_wr(gosm_pkg::PIN0_OUTPUT_CONTROL_OFFSET + 8'(p), c);
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    task automatic drive_in(input logic [1:0][3:0] g, input logic [1:0] lk,
            input logic [1:0] ps, input logic [1:0] en, input logic fs);
        @(posedge clk_sys);
        rx_remote_gpio <= g;
        rx_lock <= lk;
        rx_pass <= ps;
        rx_port_enable <= en;
        frame_sync_signal <= fs;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_enable;
        `CHK(pin_oe, 2'h0)
        `CHK(pin_out, 2'h0)
        reg_rd(8'h10, rd);
        `CHK(rd, 8'h00)
        reg_rd(8'h11, rd);
        `CHK(rd, 8'h00)
        reg_rd(8'h12, rd);
        `CHK(rd, 8'h00)
        set_pin(0, 8'h03);
        `CHK(pin_oe, 2'h1)
        set_pin(1, 8'h91);
        drive_in('0, 2'h0, 2'h0, 2'h0, 1'b1);
        `CHK(pin_out[1], 1'b1)
        `CHK(pin_level[1], 1'b1)
        set_pin(0, 8'h02);
        `CHK(pin_oe, 2'h2)
        reg_rd(8'h11, rd);
        `CHK(rd, 8'h91)
    endtask

    task automatic t_rx_gpio;
        logic [1:0][3:0] g;
        for (int p = 0; p < 2; p++) begin
            for (int port = 0; port < 2; port++) begin
                for (int sel = 0; sel < 4; sel++) begin
                    set_pin(p, {sel[2:0], port[2:0], 2'b01});
                    g = '0;
                    g[port][sel] = 1'b1;
                    drive_in(g, 2'h0, 2'h0, 2'h0, 1'b0);
                    `CHK(pin_out[p], 1'b1)
                    drive_in(~g, 2'h3, 2'h3, 2'h3, 1'b1);
                    `CHK(pin_out[p], 1'b0)
                end
            end
        end
    endtask

    task automatic t_rx_status;
        logic [1:0] m;
        for (int p = 0; p < 2; p++) begin
            for (int port = 0; port < 2; port++) begin
                for (int sel = 4; sel < 6; sel++) begin
                    set_pin(p, {sel[2:0], port[2:0], 2'b01});
                    m = 2'h1 << port;
                    drive_in('1, m, ~m, 2'h3, 1'b1);
                    `CHK(pin_out[p], (sel == 4))
                    drive_in('1, ~m, m, 2'h3, 1'b1);
                    `CHK(pin_out[p], (sel == 5))
                end
            end
        end
    endtask

    // Unused value bit and frame sync are set against the expected level
    task automatic t_dev_status;
        gosm_case_t c;
        logic v;
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 14; i++) begin
                c = DEV_CASES[i];
                v = (c.sel == 3'h0) ? c.exp : ~c.exp;
                set_pin(p, {c.sel, 3'h4, v, 1'b1});
                drive_in('1, c.lk, c.ps, c.en, (c.sel == 3'h4) ? c.exp : ~c.exp);
                `CHK(pin_out[p], c.exp)
            end
        end
    endtask

    task automatic t_reserved;
        logic rsv;
        drive_in('1, 2'h3, 2'h3, 2'h3, 1'b1);
        for (int p = 0; p < 2; p++) begin
            for (int src = 0; src < 8; src++) begin
                for (int sel = 0; sel < 8; sel++) begin
                    rsv = !(src inside {0, 1, 4}) || (src < 2 && sel > 5) ||
                        (src == 4 && sel > 4);
                    if (rsv) begin
                        set_pin(p, {sel[2:0], src[2:0], 2'b11});
                        `CHK(pin_out[p], 1'b0)
                        `CHK(pin_oe[p], 1'b1)
                        reg_rd(gosm_pkg::PIN0_OUTPUT_CONTROL_OFFSET + 8'(p), rd);
                        `CHK(rd, {sel[2:0], src[2:0], 2'b11})
                    end
                end
            end
        end
    endtask

    // Write, read on the next edge, then read and write in one cycle
    task automatic t_back_to_back;
        @(posedge clk_sys);
        reg_wr_en <= 1'b1;
        reg_addr <= gosm_pkg::PIN1_OUTPUT_CONTROL_OFFSET;
        reg_wdata <= 8'h55;
        @(posedge clk_sys);
        reg_wr_en <= 1'b0;
        reg_rd_en <= 1'b1;
        @(posedge clk_sys);
        reg_wr_en <= 1'b1;
        reg_wdata <= 8'haa;
        #1;
        `CHK(reg_rdata, 8'h55)
        @(posedge clk_sys);
        reg_wr_en <= 1'b0;
        reg_rd_en <= 1'b0;
        #1;
        `CHK(reg_rd_valid, 1'b1)
        `CHK(reg_rdata, 8'h55)
        reg_rd(gosm_pkg::PIN1_OUTPUT_CONTROL_OFFSET, rd);
        `CHK(rd, 8'haa)
    endtask

    // ----------------------------------------------------------------
    // Verdict and run control
    // ----------------------------------------------------------------
    task automatic end_sim;
        if (error_cnt == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Whole run needs about 1300 cycles; this leaves ample margin
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            $display("[ERR] %0t timeout", $time);
            end_sim();
        end
    end

    initial begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        #1;
        t_reset_enable();
        t_back_to_back();
        t_rx_gpio();
        t_rx_status();
        t_dev_status();
        t_reserved();
        end_sim();
    end
endmodule // gosm_output_mux_tb

`default_nettype wire

// [dv/gosm_pin_load.sv]
// Model of the board circuitry hanging on one local output pin.
// Assumes pin_out and pin_oe come straight from the output multiplexer.
`timescale 1ns/1ps
`default_nettype none

module gosm_pin_load (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic pin_level
);
    logic last_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            last_q <= 1'b0;
        end else if (pin_oe) begin
            last_q <= pin_out;
        end
    end

    // Floating pin: no keeper, so never trust the old level
    assign pin_level = pin_oe ? pin_out : ~last_q;
endmodule // gosm_pin_load

`default_nettype wire

// [logic/gosm_output_mux.sv]
// Output source multiplexer and driver control for local pins 0 and 1.
// Assumes register accesses arrive as one-cycle strobes from the serial
// control bus slave, and that lock, pass, remote GPIO and frame sync come
// from logic on clk_sys.
`timescale 1ns/1ps
`default_nettype none

module gosm_output_mux #(
    parameter int NUM_PINS = gosm_pkg::GOSM_NUM_PINS
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rd_valid,
    input wire logic [1:0][3:0] rx_remote_gpio,
    input wire logic [1:0] rx_lock,
    input wire logic [1:0] rx_pass,
    input wire logic [1:0] rx_port_enable,
    input wire logic frame_sync_signal,
    output logic [NUM_PINS-1:0] pin_out,
    output logic [NUM_PINS-1:0] pin_oe
);

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [1:0][7:0] CTRL_OFFSET = {
        gosm_pkg::PIN1_OUTPUT_CONTROL_OFFSET,
        gosm_pkg::PIN0_OUTPUT_CONTROL_OFFSET
    };

    logic [NUM_PINS-1:0][7:0] ctrl_q;
    logic [NUM_PINS-1:0] level;
    logic [NUM_PINS-1:0] pin_out_q;
    logic [NUM_PINS-1:0] pin_oe_q;
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    logic rd_valid_q;

    // ----------------------------------------------------------------
    // Per-pin control, decode and drivers
    // ----------------------------------------------------------------
    generate
        for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
            gosm_pin_if pin_bus ();

            assign pin_bus.ctrl = ctrl_q[i];
            assign pin_bus.rx_gpio = rx_remote_gpio;
            assign pin_bus.rx_lock = rx_lock;
            assign pin_bus.rx_pass = rx_pass;
            assign pin_bus.rx_port_enable = rx_port_enable;
            assign pin_bus.frame_sync = frame_sync_signal;
            assign level[i] = pin_bus.level;

            gosm_pin_mux u_mux (
                .pin(pin_bus.mux)
            );

            // Same field layout for every pin; only the offset differs
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    ctrl_q[i] <= gosm_pkg::PIN_OUTPUT_CONTROL_RESET;
                end else if (reg_wr_en && reg_addr == CTRL_OFFSET[i]) begin
                    ctrl_q[i] <= reg_wdata;
                end
            end

            // Registered level keeps the pin free of decode glitches
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    pin_out_q[i] <= 1'b0;
                end else begin
                    pin_out_q[i] <= level[i];
                end
            end

            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    pin_oe_q[i] <= 1'b0;
                end else begin
                    pin_oe_q[i] <= ctrl_q[i][gosm_pkg::EN_BIT];
                end
            end

            // --------------------------------------------------------
            // Checks on this pin
            // --------------------------------------------------------
            property p_rx_gpio;
                @(posedge clk_sys) disable iff (!rst_n)
                (ctrl_q[i][4:3] == 2'b00 && ctrl_q[i][7:5] <= gosm_pkg::SEL_RX_GPIO_LAST)
                |=> pin_out_q[i] ==
                    $past(rx_remote_gpio[ctrl_q[i][2]][ctrl_q[i][6:5]]);
            endproperty
            a_rx_gpio: assert property (p_rx_gpio)
                else $error("Pin does not follow remote GPIO of chosen port");

            property p_rx_lock_pass;
                @(posedge clk_sys) disable iff (!rst_n)
                (ctrl_q[i][4:3] == 2'b00 && ctrl_q[i][7:6] == 2'b10)
                |=> pin_out_q[i] == ($past(ctrl_q[i][5]) ?
                    $past(rx_pass[ctrl_q[i][2]]) : $past(rx_lock[ctrl_q[i][2]]));
            endproperty
            a_rx_lock_pass: assert property (p_rx_lock_pass)
                else $error("Pin does not carry port lock or pass");

            property p_src_reserved;
                @(posedge clk_sys) disable iff (!rst_n)
                (ctrl_q[i][4:3] == 2'b01 ||
                 (ctrl_q[i][4] && ctrl_q[i][3:2] != 2'b00))
                |=> !pin_out_q[i];
            endproperty
            a_src_reserved: assert property (p_src_reserved)
                else $error("Reserved source code drives a high level");

            property p_dev_reg_value;
                @(posedge clk_sys) disable iff (!rst_n)
                ctrl_q[i][7:2] == {gosm_pkg::SEL_DEV_REG_VALUE, gosm_pkg::SRC_DEVICE}
                |=> pin_out_q[i] == $past(ctrl_q[i][gosm_pkg::VAL_BIT]);
            endproperty
            a_dev_reg_value: assert property (p_dev_reg_value)
                else $error("Pin does not carry its value bit");

            property p_dev_or_lock;
                @(posedge clk_sys) disable iff (!rst_n)
                ctrl_q[i][7:2] == {gosm_pkg::SEL_DEV_OR_LOCK, gosm_pkg::SRC_DEVICE}
                |=> pin_out_q[i] == (|($past(rx_lock) & $past(rx_port_enable)));
            endproperty
            a_dev_or_lock: assert property (p_dev_or_lock)
                else $error("OR of enabled lock is wrong");

            property p_dev_and_lock;
                @(posedge clk_sys) disable iff (!rst_n)
                ctrl_q[i][7:2] == {gosm_pkg::SEL_DEV_AND_LOCK, gosm_pkg::SRC_DEVICE}
                |=> pin_out_q[i] == ((|$past(rx_port_enable)) &&
                    (($past(rx_lock) & $past(rx_port_enable)) == $past(rx_port_enable)));
            endproperty
            a_dev_and_lock: assert property (p_dev_and_lock)
                else $error("AND of enabled lock is wrong");

            property p_dev_and_pass;
                @(posedge clk_sys) disable iff (!rst_n)
                ctrl_q[i][7:2] == {gosm_pkg::SEL_DEV_AND_PASS, gosm_pkg::SRC_DEVICE}
                |=> pin_out_q[i] == ((|$past(rx_port_enable)) &&
                    (($past(rx_pass) & $past(rx_port_enable)) == $past(rx_port_enable)));
            endproperty
            a_dev_and_pass: assert property (p_dev_and_pass)
                else $error("AND of enabled pass is wrong");

            property p_dev_frame_sync;
                @(posedge clk_sys) disable iff (!rst_n)
                ctrl_q[i][7:2] == {gosm_pkg::SEL_DEV_FRAME_SYNC, gosm_pkg::SRC_DEVICE}
                |=> pin_out_q[i] == $past(frame_sync_signal);
            endproperty
            a_dev_frame_sync: assert property (p_dev_frame_sync)
                else $error("Pin does not carry frame sync");

            property p_value_write;
                @(posedge clk_sys) disable iff (!rst_n)
                (reg_wr_en && reg_addr == CTRL_OFFSET[i] &&
                 reg_wdata[7:2] == {gosm_pkg::SEL_DEV_REG_VALUE, gosm_pkg::SRC_DEVICE})
                |=> ##1 pin_out_q[i] == $past(reg_wdata[gosm_pkg::VAL_BIT], 2);
            endproperty
            a_value_write: assert property (p_value_write)
                else $error("Written value bit not on pin two cycles later");

            property p_enable;
                @(posedge clk_sys) disable iff (!rst_n)
                (reg_wr_en && reg_addr == CTRL_OFFSET[i])
                |=> ##1 pin_oe_q[i] == $past(reg_wdata[gosm_pkg::EN_BIT], 2);
            endproperty
            a_enable: assert property (p_enable)
                else $error("Driver enable does not follow bit 0");

            property p_dev_reserved_sel;
                @(posedge clk_sys) disable iff (!rst_n)
                (ctrl_q[i][4:2] == gosm_pkg::SRC_DEVICE && ctrl_q[i][7:5] > 3'h4) ||
                (ctrl_q[i][4:3] == 2'b00 && ctrl_q[i][7:6] == 2'b11)
                |=> !pin_out_q[i];
            endproperty
            a_dev_reserved_sel: assert property (p_dev_reserved_sel)
                else $error("Reserved select code drives a high level");

            property p_ctrl_write;
                @(posedge clk_sys) disable iff (!rst_n)
                (reg_wr_en && reg_addr == CTRL_OFFSET[i])
                |=> ctrl_q[i] == $past(reg_wdata);
            endproperty
            a_ctrl_write: assert property (p_ctrl_write)
                else $error("Write to own offset not stored");

            property p_ctrl_hold;
                @(posedge clk_sys) disable iff (!rst_n)
                !(reg_wr_en && reg_addr == CTRL_OFFSET[i])
                |=> $stable(ctrl_q[i]);
            endproperty
            a_ctrl_hold: assert property (p_ctrl_hold)
                else $error("Control changed without a write to its offset");

            property p_oe_off;
                @(posedge clk_sys) disable iff (!rst_n)
                !ctrl_q[i][gosm_pkg::EN_BIT] |=> !pin_oe_q[i];
            endproperty
            a_oe_off: assert property (p_oe_off)
                else $error("Driver enabled while bit 0 is clear");

            property p_read_ctrl;
                @(posedge clk_sys) disable iff (!rst_n)
                (reg_rd_en && reg_addr == CTRL_OFFSET[i])
                |=> rd_valid_q && rdata_q == $past(ctrl_q[i]);
            endproperty
            a_read_ctrl: assert property (p_read_ctrl)
                else $error("Control byte does not read back at its offset");
        end
    endgenerate

    // ----------------------------------------------------------------
    // Register read
    // ----------------------------------------------------------------
    always_comb begin
        rdata_d = gosm_pkg::UNMAPPED_READ_VALUE;
        for (int k = 0; k < NUM_PINS; k++) begin
            if (reg_addr == CTRL_OFFSET[k]) begin
                rdata_d = ctrl_q[k];
            end
        end
    end

    // Read-before-write: a same-cycle write shows on the next read only
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (reg_rd_en) begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= reg_rd_en;
        end
    end

    property p_pin1_readback;
        @(posedge clk_sys) disable iff (!rst_n)
        (reg_wr_en && reg_addr == gosm_pkg::PIN1_OUTPUT_CONTROL_OFFSET)
        ##1 (reg_rd_en && !reg_wr_en && reg_addr == gosm_pkg::PIN1_OUTPUT_CONTROL_OFFSET)
        |=> rd_valid_q && rdata_q == $past(reg_wdata, 2);
    endproperty
    a_pin1_readback: assert property (p_pin1_readback)
        else $error("Pin 1 control does not read back at 0x11");

    // ----------------------------------------------------------------
    // Read port checks
    // ----------------------------------------------------------------
    property p_rd_valid;
        @(posedge clk_sys) disable iff (!rst_n)
        1'b1 |=> rd_valid_q == $past(reg_rd_en);
    endproperty
    a_rd_valid: assert property (p_rd_valid)
        else $error("Read valid is not one cycle after the read strobe");

    property p_rd_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        !reg_rd_en |=> $stable(rdata_q);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("Read data changed without a read strobe");

    // Unmapped offsets read as a fixed value, never stale data
    property p_unmapped_read;
        @(posedge clk_sys) disable iff (!rst_n)
        (reg_rd_en && reg_addr != gosm_pkg::PIN0_OUTPUT_CONTROL_OFFSET &&
         reg_addr != gosm_pkg::PIN1_OUTPUT_CONTROL_OFFSET)
        |=> rdata_q == gosm_pkg::UNMAPPED_READ_VALUE;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("Unmapped offset does not read the fixed value");

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign pin_out = pin_out_q;
    assign pin_oe = pin_oe_q;
    assign reg_rdata = rdata_q;
    assign reg_rd_valid = rd_valid_q;

endmodule // gosm_output_mux

`default_nettype wire

// [logic/gosm_pin_mux.sv]
// Combinational source decoder for one local output pin.
// Assumes all inputs are synchronous to the caller's clock.
`timescale 1ns/1ps
`default_nettype none

module gosm_pin_mux (
    gosm_pin_if.mux pin
);

    logic [2:0] sel;
    logic [2:0] src;
    logic port_idx;
    logic any_en;
    logic or_lock;
    logic and_lock;
    logic and_pass;

    assign sel = pin.ctrl[gosm_pkg::SEL_MSB:gosm_pkg::SEL_LSB];
    assign src = pin.ctrl[gosm_pkg::SRC_MSB:gosm_pkg::SRC_LSB];
    assign port_idx = src[0];
    assign any_en = |pin.rx_port_enable;
    // Empty port set reads low for the AND forms too, never a false "all locked"
    assign or_lock = |(pin.rx_lock & pin.rx_port_enable);
    assign and_lock = any_en && (&(pin.rx_lock | ~pin.rx_port_enable));
    assign and_pass = any_en && (&(pin.rx_pass | ~pin.rx_port_enable));

    // ----------------------------------------------------------------
    // Source and select decode
    // ----------------------------------------------------------------
    always_comb begin
        pin.level = 1'b0;
        if (src == gosm_pkg::SRC_RX_PORT0 || src == gosm_pkg::SRC_RX_PORT1) begin
            if (sel <= gosm_pkg::SEL_RX_GPIO_LAST) begin
                pin.level = pin.rx_gpio[port_idx][sel[1:0]];
            end else if (sel == gosm_pkg::SEL_RX_LOCK) begin
                pin.level = pin.rx_lock[port_idx];
            end else if (sel == gosm_pkg::SEL_RX_PASS) begin
                pin.level = pin.rx_pass[port_idx];
            end
        end else if (src == gosm_pkg::SRC_DEVICE) begin
            case (sel)
                gosm_pkg::SEL_DEV_REG_VALUE: pin.level = pin.ctrl[gosm_pkg::VAL_BIT];
                gosm_pkg::SEL_DEV_OR_LOCK: pin.level = or_lock;
                gosm_pkg::SEL_DEV_AND_LOCK: pin.level = and_lock;
                gosm_pkg::SEL_DEV_AND_PASS: pin.level = and_pass;
                gosm_pkg::SEL_DEV_FRAME_SYNC: pin.level = pin.frame_sync;
                default: pin.level = 1'b0;
            endcase
        end
    end

endmodule // gosm_pin_mux

`default_nettype wire

// [shared/gosm_pin_if.sv]
// Carrier between the register/driver top and one pin's source decoder.
// Assumes the top drives control and status, the decoder returns a level.
`timescale 1ns/1ps
`default_nettype none

interface gosm_pin_if;
    logic [7:0] ctrl;
    logic [1:0][3:0] rx_gpio;
    logic [1:0] rx_lock;
    logic [1:0] rx_pass;
    logic [1:0] rx_port_enable;
    logic frame_sync;
    logic level;

    modport drv (
        output ctrl,
        output rx_gpio,
        output rx_lock,
        output rx_pass,
        output rx_port_enable,
        output frame_sync,
        input level
    );

    modport mux (
        input ctrl,
        input rx_gpio,
        input rx_lock,
        input rx_pass,
        input rx_port_enable,
        input frame_sync,
        output level
    );
endinterface : gosm_pin_if

`default_nettype wire

// [shared/gosm_pkg.sv]
// Constants for the output source multiplexer of local pins 0 and 1.
// Assumes an 8-bit register address space reached over the serial control bus.
package gosm_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int GOSM_NUM_PINS = 2;
    localparam int GOSM_NUM_PORTS = 2;
    localparam int GOSM_NUM_REMOTE = 4;
    localparam int GOSM_ADDR_W = 8;
    localparam int GOSM_DATA_W = 8;

    // ----------------------------------------------------------------
    // Register offsets and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] PIN0_OUTPUT_CONTROL_OFFSET = 8'h10;
    localparam logic [7:0] PIN1_OUTPUT_CONTROL_OFFSET = 8'h11;
    localparam logic [7:0] PIN_OUTPUT_CONTROL_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int SEL_MSB = 7;
    localparam int SEL_LSB = 5;
    localparam int SRC_MSB = 4;
    localparam int SRC_LSB = 2;
    localparam int VAL_BIT = 1;
    localparam int EN_BIT = 0;

    // ----------------------------------------------------------------
    // Source codes
    // ----------------------------------------------------------------
    localparam logic [2:0] SRC_RX_PORT0 = 3'h0;
    localparam logic [2:0] SRC_RX_PORT1 = 3'h1;
    localparam logic [2:0] SRC_DEVICE = 3'h4;

    // ----------------------------------------------------------------
    // Select codes, receive port source
    // ----------------------------------------------------------------
    localparam logic [2:0] SEL_RX_GPIO_LAST = 3'h3;
    localparam logic [2:0] SEL_RX_LOCK = 3'h4;
    localparam logic [2:0] SEL_RX_PASS = 3'h5;

    // ----------------------------------------------------------------
    // Select codes, device status source
    // ----------------------------------------------------------------
    localparam logic [2:0] SEL_DEV_REG_VALUE = 3'h0;
    localparam logic [2:0] SEL_DEV_OR_LOCK = 3'h1;
    localparam logic [2:0] SEL_DEV_AND_LOCK = 3'h2;
    localparam logic [2:0] SEL_DEV_AND_PASS = 3'h3;
    localparam logic [2:0] SEL_DEV_FRAME_SYNC = 3'h4;

endpackage : gosm_pkg
